// file: src/sdc_dev.sv
// Device end: command decoder of the synchronous DRAM
// Summary of operation
// - Decode command from pins at rising edge.
// - Row-open select picks strobes or upper address.
// - Field widths sized per built part.
// - Group/bank select bank, or mode register.
// - Address bit 17 reserved during mode set.
// - Reset input is asynchronous only, held high; here it is synchronised through two flops and acts at the clock edge.
// - Bursts never cut; fixed/per-command from mode.
// - Chop pin picks four/eight; bit 10 auto-close.
// - One reserved encoding never issued.
// - Valid fields driven to defined levels.
// - Termination ignored; unavailable in sleep renew.
// - Sleep renew exit synchronous from controller.
// - Null only for power-saving exit, gear-down.
// - Null never replaces a deselect.
// - No refresh activity during power-down.
// - Two reference ranges: 60-92% and 45-77%.
// - Fifty reference settings, about 0.65% steps.
// - Chip select high executes no new command.
// - Mode set drives all three strobes low.
`timescale 1ns/100ps
module sdc_dev
  import sdc_pkg::*;
#(
  parameter int BANKS_PER_GROUP = 4,
  parameter int GROUPS          = 4
) (
  // Clock and reset
  input  wire logic                    clock_i,
  input  wire logic                    rst_i,
  // Pin side
  sdc_bus_if.dev                       bus,
  // Decoded command
  output sdc_pkg::sdc_cmd_t            cmd_o,
  output logic                         cmd_valid_o,
  output logic [GROUP_W-1:0]           cmd_group_o,
  output logic [BANK_W-1:0]            cmd_bank_o,
  output logic [ADDR_W-1:0]            cmd_addr_o,
  output logic                         cmd_auto_close_o,
  output logic                         cmd_chop_o,
  // Device state
  output logic                         sleep_o,
  output logic                         powerdown_o,
  output logic                         termination_o,
  output logic                         ref_enable_o,
  output logic                         ref_range_o,
  output logic [REF_VALUE_W-1:0]       ref_value_o,
  output logic [15:0]                  ref_level_o,
  output logic                         burst_otf_o
);
  import sdc_pkg::*;

  // Geometry that the select fields cannot address is refused at elaboration
  if (GROUPS < 1 || BANKS_PER_GROUP < 1 ||
      GROUPS > (1 << GROUP_W) || BANKS_PER_GROUP > (1 << BANK_W)) begin : g_geom_check
    $error("Bank geometry does not fit the select fields");
  end

  // ----------------------------------------------------------------
  // Input synchronisers (pins come from outside the clock domain)
  // ----------------------------------------------------------------
  localparam int PIN_W = 7 + GROUP_W + BANK_W + ADDR_W;
  logic [PIN_W-1:0] pin_meta_reg;
  logic [PIN_W-1:0] pin_reg;
  logic             rstn_meta_reg;
  logic             rstn_reg;

  always_ff @(posedge clock_i) begin
    pin_meta_reg <= {bus.chip_select_n, bus.clock_gate, bus.row_open_select,
                     bus.row_strobe_pin, bus.column_strobe_pin, bus.write_strobe_pin,
                     bus.termination_control, bus.group_select, bus.bank_select, bus.addr};
    pin_reg      <= pin_meta_reg;
  end

  // Pin reset is sampled as a level; it is a reset input, not a command
  always_ff @(posedge clock_i) begin
    rstn_meta_reg <= bus.reset_n;
    rstn_reg      <= rstn_meta_reg;
  end

  logic               cs_n, gate, row_open, ras, cas, we, term;
  logic [GROUP_W-1:0] grp;
  logic [BANK_W-1:0]  bank;
  logic [ADDR_W-1:0]  addr;
  logic [ADDR_W-1:0]  full_addr;
  logic               gate_prev_reg;
  logic               dev_rst;

  assign {cs_n, gate, row_open, ras, cas, we, term, grp, bank, addr} = pin_reg;
  assign dev_rst = rst_i | ~rstn_reg;

  // When row-open select is low the strobes are upper row address bits
  always_comb begin
    full_addr = addr;
    if (!row_open) begin
      full_addr[STROBE_LO_BIT +: 3] = {ras, cas, we};
    end
  end

  // ----------------------------------------------------------------
  // Command classification
  // ----------------------------------------------------------------
  sdc_cmd_t cmd;

  always_comb begin
    cmd = SDC_CMD_DESELECT;
    if (gate_prev_reg && !gate) begin
      // Only deselect or refresh may drop the clock gate
      if (cs_n)
        cmd = SDC_CMD_PD_ENTRY;
      else if (row_open && {ras, cas, we} == 3'h1)
        cmd = SDC_CMD_SLEEP_ENTRY;
      else
        cmd = SDC_CMD_RESERVED;
    end else if (!gate_prev_reg && gate) begin
      // Exit detected synchronously on the first high gate
      cmd = sleep_o ? SDC_CMD_SLEEP_EXIT : SDC_CMD_PD_EXIT;
    end else if (!gate) begin
      cmd = SDC_CMD_DESELECT;
    end else if (cs_n) begin
      cmd = SDC_CMD_DESELECT;
    end else if (!row_open) begin
      cmd = SDC_CMD_ACTIVATE;
    end else begin
      // Decode on the levels at the edge; termination is not looked at
      case ({ras, cas, we})
        3'h0: cmd = SDC_CMD_MODE_SET;
        3'h1: cmd = SDC_CMD_REFRESH;
        3'h2: cmd = addr[AUTO_CLOSE_BIT] ? SDC_CMD_ALL_CLOSE : SDC_CMD_BANK_CLOSE;
        3'h3: cmd = SDC_CMD_RESERVED;
        3'h4: cmd = SDC_CMD_WRITE;
        3'h5: cmd = SDC_CMD_READ;
        3'h6: cmd = addr[AUTO_CLOSE_BIT] ? SDC_CMD_CAL_LONG : SDC_CMD_CAL_SHORT;
        3'h7: cmd = SDC_CMD_NULL;
        default: cmd = SDC_CMD_RESERVED;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Decoded command outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (dev_rst) begin
      cmd_o            <= SDC_CMD_DESELECT;
      cmd_valid_o      <= 1'b0;
      cmd_group_o      <= '0;
      cmd_bank_o       <= '0;
      cmd_addr_o       <= '0;
      cmd_auto_close_o <= 1'b0;
      cmd_chop_o       <= 1'b0;
    end else begin
      cmd_o            <= cmd;
      // Reserved, null and deselect cycles carry no action
      cmd_valid_o      <= !(cmd inside {SDC_CMD_DESELECT, SDC_CMD_RESERVED, SDC_CMD_NULL});
      cmd_group_o      <= grp;
      cmd_bank_o       <= bank;
      cmd_addr_o       <= full_addr;
      cmd_auto_close_o <= addr[AUTO_CLOSE_BIT];
      // Chop only honoured in per-command burst mode
      cmd_chop_o       <= burst_otf_o & ~addr[BURST_CHOP_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Low-power state
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (dev_rst) begin
      gate_prev_reg <= 1'b1;
      sleep_o       <= 1'b0;
      powerdown_o   <= 1'b0;
    end else begin
      gate_prev_reg <= gate;
      if (cmd == SDC_CMD_SLEEP_ENTRY)
        sleep_o <= 1'b1;
      else if (cmd == SDC_CMD_SLEEP_EXIT)
        sleep_o <= 1'b0;
      // No refresh is ever started while powered down
      if (cmd == SDC_CMD_PD_ENTRY)
        powerdown_o <= 1'b1;
      else if (cmd == SDC_CMD_PD_EXIT)
        powerdown_o <= 1'b0;
    end
  end

  // Termination disabled while in sleep renew
  always_ff @(posedge clock_i) begin
    if (dev_rst)
      termination_o <= 1'b0;
    else
      termination_o <= term & ~sleep_o;
  end

  // ----------------------------------------------------------------
  // Mode register fields held by the decoder
  // ----------------------------------------------------------------
  logic mode_hit;
  assign mode_hit = (cmd == SDC_CMD_MODE_SET);

  always_ff @(posedge clock_i) begin
    if (dev_rst) begin
      ref_enable_o <= 1'b0;
      ref_range_o  <= REF_RANGE_RST;
      ref_value_o  <= REF_VALUE_RST;
      burst_otf_o  <= 1'b0;
    end else if (mode_hit) begin
      // Bit 17 is ignored here
      if ({grp[0], bank} == REF_MODE_SEL) begin
        ref_enable_o <= addr[REF_ENABLE_BIT];
        ref_range_o  <= addr[REF_RANGE_BIT];
        // Settings past the last step are refused
        if (addr[REF_VALUE_LSB +: REF_VALUE_W] < REF_STEPS)
          ref_value_o <= addr[REF_VALUE_LSB +: REF_VALUE_W];
      end
      if ({grp[0], bank} == BURST_MODE_SEL)
        burst_otf_o <= (addr[1:0] == BURST_OTF);
    end
  end

  // Level in hundredths of a percent of the I/O supply
  always_ff @(posedge clock_i) begin
    if (dev_rst)
      ref_level_o <= 16'(RANGE1_FLOOR);
    else
      ref_level_o <= 16'((ref_range_o ? RANGE2_FLOOR : RANGE1_FLOOR)
                         + REF_STEP * int'(ref_value_o));
  end

endmodule

// file: src/sdc_pkg.sv
// Package of command encodings, field widths and reference-level constants for the decoder
package sdc_pkg;

  // ----------------------------------------------------------------
  // Address field widths (sized for the part that is built)
  // ----------------------------------------------------------------
  localparam int GROUP_W = 2;
  localparam int BANK_W  = 2;
  localparam int ADDR_W  = 18;
  localparam int OPC_W   = 18;

  // ----------------------------------------------------------------
  // Address bit positions
  // ----------------------------------------------------------------
  localparam int AUTO_CLOSE_BIT = 10;
  localparam int BURST_CHOP_BIT = 12;
  localparam int RESV_MODE_BIT  = 17;
  localparam int STROBE_LO_BIT  = 14;

  // ----------------------------------------------------------------
  // Mode register 6 reference fields and mode register 0 burst fields
  // ----------------------------------------------------------------
  localparam logic [2:0] REF_MODE_SEL   = 3'h6;
  localparam int         REF_VALUE_LSB  = 0;
  localparam int         REF_VALUE_W    = 6;
  localparam int         REF_RANGE_BIT  = 6;
  localparam int         REF_ENABLE_BIT = 7;
  localparam logic [5:0] REF_STEPS      = 6'h32;
  localparam logic [5:0] REF_VALUE_RST  = 6'h00;
  localparam logic       REF_RANGE_RST  = 1'b0;
  localparam int         BURST_MODE_BIT = 0;
  localparam logic [1:0] BURST_OTF      = 2'h1;
  localparam logic [2:0] BURST_MODE_SEL = 3'h0;
  // Range floors and step in hundredths of a percent of the I/O supply
  localparam int RANGE1_FLOOR = 6000;
  localparam int RANGE2_FLOOR = 4500;
  localparam int REF_STEP     = 65;

  // ----------------------------------------------------------------
  // Decoded command classes
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    SDC_CMD_DESELECT, SDC_CMD_MODE_SET, SDC_CMD_REFRESH, SDC_CMD_SLEEP_ENTRY,
    SDC_CMD_SLEEP_EXIT, SDC_CMD_BANK_CLOSE, SDC_CMD_ALL_CLOSE, SDC_CMD_ACTIVATE,
    SDC_CMD_WRITE, SDC_CMD_READ, SDC_CMD_NULL, SDC_CMD_PD_ENTRY, SDC_CMD_PD_EXIT,
    SDC_CMD_CAL_LONG, SDC_CMD_CAL_SHORT, SDC_CMD_RESERVED
  } sdc_cmd_t;

  typedef enum logic [2:0] {
    SDC_REQ_IDLE, SDC_REQ_MODE_SET, SDC_REQ_REFRESH, SDC_REQ_ACTIVATE,
    SDC_REQ_BANK_CLOSE, SDC_REQ_WRITE, SDC_REQ_READ, SDC_REQ_CAL
  } sdc_req_t;

endpackage

// file: src/sdc_bus_if.sv
// Interface carrying the command/address pins between controller and device
`timescale 1ns/100ps
interface sdc_bus_if;
  import sdc_pkg::*;
  logic                 reset_n;
  logic                 chip_select_n;
  logic                 clock_gate;
  logic                 row_open_select;
  logic                 row_strobe_pin;
  logic                 column_strobe_pin;
  logic                 write_strobe_pin;
  logic [GROUP_W-1:0]   group_select;
  logic [BANK_W-1:0]    bank_select;
  logic [ADDR_W-1:0]    addr;
  logic                 termination_control;

  modport ctrl (output reset_n, chip_select_n, clock_gate, row_open_select, row_strobe_pin,
                column_strobe_pin, write_strobe_pin, group_select, bank_select, addr,
                termination_control);
  modport dev  (input reset_n, chip_select_n, clock_gate, row_open_select, row_strobe_pin,
                column_strobe_pin, write_strobe_pin, group_select, bank_select, addr,
                termination_control);
endinterface

// file: src/sdc_ctrl.sv
// Controller end: turns user requests into legal command/address pin levels
`timescale 1ns/100ps
module sdc_ctrl
  import sdc_pkg::*;
(
  // Clock and reset
  input  wire logic                 clock_i,
  input  wire logic                 rst_i,
  // User request
  input  wire sdc_pkg::sdc_req_t    req_i,
  input  wire logic                 req_valid_i,
  input  wire logic [GROUP_W-1:0]   req_group_i,
  input  wire logic [BANK_W-1:0]    req_bank_i,
  input  wire logic [ADDR_W-1:0]    req_addr_i,
  input  wire logic                 req_auto_close_i,
  input  wire logic                 req_chop_i,
  input  wire logic                 req_all_i,
  input  wire logic                 req_long_i,
  input  wire logic                 clock_gate_i,
  input  wire logic                 termination_i,
  output logic                      req_ready_o,
  // Pin side
  sdc_bus_if.ctrl                   bus
);
  import sdc_pkg::*;

  logic [ADDR_W-1:0] addr_reg;
  logic [2:0]        strobe_reg;
  logic              cs_n_reg;
  logic              row_open_reg;
  logic [GROUP_W-1:0] grp_reg;
  logic [BANK_W-1:0]  bank_reg;
  logic              gate_reg;
  logic              term_reg;

  assign req_ready_o = 1'b1;

  // ----------------------------------------------------------------
  // Command drive: all pins but reset_n registered so they are stable at the edge
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      cs_n_reg     <= 1'b1;
      row_open_reg <= 1'b1;
      strobe_reg   <= 3'h7;
      addr_reg     <= '0;
      grp_reg    <= '0;
      bank_reg   <= '0;
    end else begin
      // Idle cycles are deselects, never the null encoding
      cs_n_reg   <= 1'b1;
      row_open_reg <= 1'b1;
      strobe_reg <= 3'h7;
      // Defined levels on every valid field
      addr_reg   <= req_addr_i;
      grp_reg    <= req_group_i;
      bank_reg   <= req_bank_i;
      if (req_valid_i) begin
        cs_n_reg <= 1'b0;
        case (req_i)
          SDC_REQ_MODE_SET: begin
            strobe_reg <= 3'h0;
            addr_reg[RESV_MODE_BIT] <= 1'b0;
          end
          SDC_REQ_REFRESH:  strobe_reg <= 3'h1;
          SDC_REQ_ACTIVATE: begin
            row_open_reg <= 1'b0;
            strobe_reg <= req_addr_i[STROBE_LO_BIT +: 3];
          end
          SDC_REQ_BANK_CLOSE: begin
            strobe_reg <= 3'h2;
            addr_reg[AUTO_CLOSE_BIT] <= req_all_i;
          end
          SDC_REQ_WRITE, SDC_REQ_READ: begin
            strobe_reg <= (req_i == SDC_REQ_READ) ? 3'h5 : 3'h4;
            addr_reg[AUTO_CLOSE_BIT] <= req_auto_close_i;
            addr_reg[BURST_CHOP_BIT] <= ~req_chop_i;
          end
          SDC_REQ_CAL: begin
            strobe_reg <= 3'h6;
            addr_reg[AUTO_CLOSE_BIT] <= req_long_i;
          end
          default: cs_n_reg <= 1'b1;
        endcase
      end
    end
  end

  // Clock gate changes are synchronous to the clock, also for sleep exit
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      gate_reg <= 1'b1;
      term_reg <= 1'b0;
    end else begin
      gate_reg <= clock_gate_i;
      term_reg <= termination_i;
    end
  end

  // ----------------------------------------------------------------
  // Pin mapping
  // ----------------------------------------------------------------
  assign bus.reset_n             = ~rst_i;
  assign bus.chip_select_n       = cs_n_reg;
  assign bus.clock_gate          = gate_reg;
  assign bus.row_open_select     = row_open_reg;
  assign bus.row_strobe_pin      = strobe_reg[2];
  assign bus.column_strobe_pin   = strobe_reg[1];
  assign bus.write_strobe_pin    = strobe_reg[0];
  assign bus.group_select        = grp_reg;
  assign bus.bank_select         = bank_reg;
  assign bus.addr                = addr_reg;
  assign bus.termination_control = term_reg;

endmodule

// file: tb/sdc_bus_props.sv
// Checker on the command/address pins joining the two ends
`timescale 1ns/100ps
module sdc_bus_props (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // Pin levels
  input wire logic reset_n,
  input wire logic chip_select_n,
  input wire logic clock_gate,
  input wire logic row_open_select,
  input wire logic row_strobe_pin,
  input wire logic column_strobe_pin,
  input wire logic write_strobe_pin,
  input wire logic termination_control
);
  logic       sel;
  logic [2:0] stb;

  assign sel = !chip_select_n && row_open_select;
  assign stb = {row_strobe_pin, column_strobe_pin, write_strobe_pin};

  default clocking @(posedge clock_i); endclocking
  default disable iff (rst_i);

  property p_reserved;
    !(sel && stb == 3'h3);
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved encoding");

  property p_null;
    !(sel && stb == 3'h7);
  endproperty
  a_null: assert property (p_null) else $error("null command driven");

  property p_reset_pin;
    !$past(rst_i) |-> reset_n;
  endproperty
  a_reset_pin: assert property (p_reset_pin) else $error("reset pin low");

  property p_idle_after_rst;
    $past(rst_i) |-> chip_select_n && clock_gate && !termination_control;
  endproperty
  a_idle_after_rst: assert property (p_idle_after_rst) else $error("pins not idle");

  // Exit from either low-power state is only legal under deselect
  property p_exit_desel;
    $rose(clock_gate) |-> chip_select_n;
  endproperty
  a_exit_desel: assert property (p_exit_desel) else $error("exit not deselect");

  property p_entry_cmd;
    $fell(clock_gate) |-> chip_select_n || (row_open_select && stb == 3'h1);
  endproperty
  a_entry_cmd: assert property (p_entry_cmd) else $error("bad gate entry");

  property p_low_desel;
    !clock_gate && !$past(clock_gate) |-> chip_select_n;
  endproperty
  a_low_desel: assert property (p_low_desel) else $error("command while gated");

  property p_act_sel;
    !row_open_select |-> !chip_select_n;
  endproperty
  a_act_sel: assert property (p_act_sel) else $error("row open unselected");
endmodule

// file: tb/tb.sv
// Self-checking bench joining controller and decoder ends
`timescale 1ns/100ps
module tb;
  import sdc_pkg::*;
  typedef struct packed {
    sdc_req_t            kind;
    logic [GROUP_W-1:0]  grp;
    logic [BANK_W-1:0]   bnk;
    logic [ADDR_W-1:0]   adr;
    logic                valid, ac, chp, all, lng, gate, term, otf, chk, pg, slp;
  } sdc_rq_t;

  logic                   clock_i = 1'b0;
  logic                   rst_i = 1'b1;
  sdc_req_t               req_i = SDC_REQ_IDLE;
  logic                   req_valid_i = 1'b0, req_auto_close_i = 1'b0, req_chop_i = 1'b0;
  logic                   req_all_i = 1'b0, req_long_i = 1'b0, termination_i = 1'b0;
  logic                   clock_gate_i = 1'b1;
  logic [GROUP_W-1:0]     req_group_i = 2'h0;
  logic [BANK_W-1:0]      req_bank_i = 2'h0;
  logic [ADDR_W-1:0]      req_addr_i = 18'h00000;
  sdc_cmd_t               cmd_o;
  logic                   cmd_valid_o, cmd_auto_close_o, cmd_chop_o, sleep_o, powerdown_o;
  logic                   termination_o, ref_enable_o, ref_range_o, burst_otf_o;
  logic [GROUP_W-1:0]     cmd_group_o;
  logic [BANK_W-1:0]      cmd_bank_o;
  logic [ADDR_W-1:0]      cmd_addr_o;
  logic [REF_VALUE_W-1:0] ref_value_o;
  logic [15:0]            ref_level_o;
  logic [31:0]            seed = 32'h000042A5;
  logic                   otf = 1'b0;
  logic                   gate_last = 1'b1;
  logic                   sleep_exp = 1'b0;
  logic                   req_ready_o;
  int                     err_total = 0;
  int                     n_checks = 0;
  sdc_rq_t                pend[$];

  always #2.5 clock_i = ~clock_i;

  sdc_bus_if sdc_bus_if_i ();
  sdc_ctrl sdc_ctrl_i (.clock_i(clock_i), .rst_i(rst_i), .req_i(req_i),
    .req_valid_i(req_valid_i), .req_group_i(req_group_i), .req_bank_i(req_bank_i),
    .req_addr_i(req_addr_i), .req_auto_close_i(req_auto_close_i), .req_chop_i(req_chop_i),
    .req_all_i(req_all_i), .req_long_i(req_long_i), .clock_gate_i(clock_gate_i),
    .termination_i(termination_i), .req_ready_o(req_ready_o), .bus(sdc_bus_if_i));
  sdc_dev #(.BANKS_PER_GROUP(4), .GROUPS(4)) sdc_dev_i (.clock_i(clock_i), .rst_i(rst_i),
    .bus(sdc_bus_if_i), .cmd_o(cmd_o), .cmd_valid_o(cmd_valid_o), .cmd_group_o(cmd_group_o),
    .cmd_bank_o(cmd_bank_o), .cmd_addr_o(cmd_addr_o), .cmd_auto_close_o(cmd_auto_close_o),
    .cmd_chop_o(cmd_chop_o), .sleep_o(sleep_o), .powerdown_o(powerdown_o),
    .termination_o(termination_o), .ref_enable_o(ref_enable_o), .ref_range_o(ref_range_o),
    .ref_value_o(ref_value_o), .ref_level_o(ref_level_o), .burst_otf_o(burst_otf_o));
  sdc_bus_props sdc_bus_props_i (.clock_i(clock_i), .rst_i(rst_i),
    .reset_n(sdc_bus_if_i.reset_n), .chip_select_n(sdc_bus_if_i.chip_select_n),
    .clock_gate(sdc_bus_if_i.clock_gate), .row_open_select(sdc_bus_if_i.row_open_select),
    .row_strobe_pin(sdc_bus_if_i.row_strobe_pin),
    .column_strobe_pin(sdc_bus_if_i.column_strobe_pin),
    .write_strobe_pin(sdc_bus_if_i.write_strobe_pin),
    .termination_control(sdc_bus_if_i.termination_control));

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic sdc_rq_t idle_rq();
    sdc_rq_t q;
    q      = '0;
    q.kind = SDC_REQ_IDLE;
    q.gate = 1'b1;
    q.chk  = 1'b1;
    return q;
  endfunction

  function automatic sdc_cmd_t exp_cmd(sdc_rq_t q);
    if (q.pg && !q.gate) begin
      if (!q.valid || q.kind == SDC_REQ_IDLE) return SDC_CMD_PD_ENTRY;
      return (q.kind == SDC_REQ_REFRESH) ? SDC_CMD_SLEEP_ENTRY : SDC_CMD_RESERVED;
    end
    if (!q.pg && q.gate) return q.slp ? SDC_CMD_SLEEP_EXIT : SDC_CMD_PD_EXIT;
    if (!q.gate || !q.valid) return SDC_CMD_DESELECT;
    case (q.kind)
      SDC_REQ_MODE_SET:   return SDC_CMD_MODE_SET;
      SDC_REQ_REFRESH:    return SDC_CMD_REFRESH;
      SDC_REQ_ACTIVATE:   return SDC_CMD_ACTIVATE;
      SDC_REQ_BANK_CLOSE: return q.all ? SDC_CMD_ALL_CLOSE : SDC_CMD_BANK_CLOSE;
      SDC_REQ_WRITE:      return SDC_CMD_WRITE;
      SDC_REQ_READ:       return SDC_CMD_READ;
      SDC_REQ_CAL:        return q.lng ? SDC_CMD_CAL_LONG : SDC_CMD_CAL_SHORT;
      default:            return SDC_CMD_DESELECT;
    endcase
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] want);
    n_checks++;
    if (seen !== want) begin
      err_total++;
      $display("unexpected at %0t seen %h expected %h", $time, seen, want);
    end
  endtask

  task automatic check_cmd(input sdc_rq_t o);
    sdc_cmd_t e;
    logic     rw;
    e  = exp_cmd(o);
    rw = (e == SDC_CMD_READ) || (e == SDC_CMD_WRITE);
    chk(32'(cmd_o), 32'(e));
    chk(32'(cmd_valid_o), 32'(!(e inside {SDC_CMD_DESELECT, SDC_CMD_RESERVED})));
    if (rw || e == SDC_CMD_ACTIVATE || e == SDC_CMD_BANK_CLOSE) begin
      chk(32'({cmd_group_o, cmd_bank_o}), 32'({o.grp, o.bnk}));
    end
    if (rw) begin
      chk(32'(cmd_auto_close_o), 32'(o.ac));
      chk(32'(cmd_chop_o), 32'(o.chp & o.otf));
    end
    if (e == SDC_CMD_ACTIVATE) begin
      chk(32'(cmd_addr_o), 32'(o.adr));
    end
  endtask

  // Decoded result shows four edges after the request edge
  task automatic step(input sdc_rq_t q);
    @(posedge clock_i);
    req_i            <= q.kind;
    req_valid_i      <= q.valid;
    req_group_i      <= q.grp;
    req_bank_i       <= q.bnk;
    req_addr_i       <= q.adr;
    req_auto_close_i <= q.ac;
    req_chop_i       <= q.chp;
    req_all_i        <= q.all;
    req_long_i       <= q.lng;
    clock_gate_i     <= q.gate;
    termination_i    <= q.term;
    q.otf = otf;
    q.pg  = gate_last;
    q.slp = sleep_exp;
    gate_last = q.gate;
    if (q.pg && !q.gate) sleep_exp = q.valid && q.kind == SDC_REQ_REFRESH;
    pend.push_back(q);
    @(negedge clock_i);
    if (pend.size() > 4) begin
      q = pend.pop_front();
      if (q.chk) check_cmd(q);
    end
  endtask

  task automatic rand_run(input int n);
    sdc_rq_t     q;
    logic [31:0] v;
    repeat (n) begin
      v      = xs();
      q      = idle_rq();
      q.kind = sdc_req_t'(v[2:0]);
      if (q.kind == SDC_REQ_MODE_SET) q.kind = SDC_REQ_READ;
      q.valid = v[4:3] != 2'h0;
      {q.grp, q.bnk, q.ac, q.chp, q.all, q.lng, q.term} = v[13:5];
      v     = xs();
      q.adr = v[17:0];
      step(q);
    end
  endtask

  task automatic mode_set(input logic [1:0] g, input logic [1:0] b, input logic [17:0] a);
    sdc_rq_t q;
    q       = idle_rq();
    q.kind  = SDC_REQ_MODE_SET;
    q.valid = 1'b1;
    q.grp   = g;
    q.bnk   = b;
    q.adr   = a;
    step(q);
    repeat (6) step(idle_rq());
  endtask

  // Gate edges are decoded and compared like any other command
  task automatic gate_phase(input logic g, input sdc_req_t k, input logic t);
    sdc_rq_t q;
    q       = idle_rq();
    q.gate  = g;
    q.term  = t;
    q.kind  = k;
    q.valid = k != SDC_REQ_IDLE;
    step(q);
    q.kind  = SDC_REQ_IDLE;
    q.valid = 1'b0;
    repeat (6) step(q);
  endtask

  task automatic summarize();
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    repeat (10) @(posedge clock_i);
    rst_i <= 1'b0;
    repeat (2) step(idle_rq());
    chk(32'(ref_level_o), 32'(RANGE1_FLOOR));
    chk(32'(burst_otf_o), 32'h0);
    chk(32'(req_ready_o), 32'h1);
    rand_run(40);
    mode_set(2'h0, 2'h0, 18'h00001);
    otf = 1'b1;
    chk(32'(burst_otf_o), 32'h1);
    mode_set(2'h1, 2'h2, 18'h000F1);
    chk(32'({ref_enable_o, ref_range_o, ref_value_o}), 32'h000000F1);
    chk(32'(ref_level_o), 32'(RANGE2_FLOOR + 49 * REF_STEP));
    mode_set(2'h1, 2'h2, 18'h000F2);
    chk(32'(ref_value_o), 32'h00000031);
    mode_set(2'h1, 2'h2, 18'h00080);
    chk(32'(ref_level_o), 32'(RANGE1_FLOOR));
    rand_run(300);
    gate_phase(1'b0, SDC_REQ_IDLE, 1'b0);
    chk(32'({powerdown_o, sleep_o}), 32'h2);
    gate_phase(1'b1, SDC_REQ_IDLE, 1'b0);
    chk(32'(powerdown_o), 32'h0);
    gate_phase(1'b0, SDC_REQ_REFRESH, 1'b1);
    chk(32'({sleep_o, termination_o}), 32'h2);
    gate_phase(1'b1, SDC_REQ_IDLE, 1'b1);
    chk(32'({sleep_o, termination_o}), 32'h1);
    repeat (6) step(idle_rq());
    summarize();
  end
endmodule
